//--- core/otsc_map.svh
/*
 * register indexes, reset values, field positions and ratios of the
 * oscillator trim, spread and clock-out block.
 * assumes: byte address on apb is four times the register index.
 */
`ifndef OTSC_MAP_SVH
`define OTSC_MAP_SVH

// register indexes, byte address = index * 4
`define OTSC_IDX_COARSE 16'hA001
`define OTSC_IDX_FINE 16'hA002
`define OTSC_IDX_CLOCK_OUTPUT_CONTROL 16'hA006
`define OTSC_IDX_SLOW 16'hA007
`define OTSC_IDX_STATUS 16'hA00C

// reset values
`define OTSC_RST_COARSE 8'h01
`define OTSC_RST_FINE 8'h80
`define OTSC_RST_CLOCK_OUTPUT_CONTROL 8'h00
`define OTSC_RST_SLOW 8'h08

// field positions and codes
`define OTSC_RATE_OFF 4'h0
`define OTSC_SLOW_RANGE_BIT 4
`define OTSC_CLOCK_OUTPUT_ENABLE_BIT 7
`define OTSC_SLOW_WR_MASK 8'h1F

// trim code limits and ratios
`define OTSC_TRIM_MIN 10'sh000
`define OTSC_TRIM_MAX 10'sh0FF
`define OTSC_SLOW32_LAST 2'h3

`endif

//--- core/otsc_pkg.sv
/*
 * types shared by the oscillator trim, spread and clock-out block.
 * assumes: nothing beyond the register header.
 */
package otsc_pkg;

    // clock-out source codes
    typedef enum logic [1:0] {
        SRC_SYS = 2'h0,
        SRC_FAST = 2'h1,
        SRC_SLOW32 = 2'h2,
        SRC_RSVD = 2'h3
    } otsc_src_t;

    // sweep direction states
    typedef enum logic {
        DIR_UP = 1'h0,
        DIR_DOWN = 1'h1
    } otsc_dir_t;

    typedef struct packed {
        logic [3:0] sweep_rate;
        logic [1:0] sweep_amplitude;
        logic [1:0] coarse_trim;
    } otsc_coarse_t;

    typedef struct packed {
        logic clock_output_enable;
        otsc_src_t clock_output_source;
        logic [4:0] clock_output_divider;
    } otsc_clock_output_control_t;

    typedef struct packed {
        logic [2:0] rsvd;
        logic slow_osc_range;
        logic [3:0] trim;
    } otsc_slow_t;

    // deviation in trim counts for an amplitude code
    function automatic logic [5:0] otsc_dev(input logic [1:0] amp);
        case (amp)
            2'h0: otsc_dev = 6'h04;
            2'h1: otsc_dev = 6'h08;
            2'h2: otsc_dev = 6'h10;
            default: otsc_dev = 6'h20;
        endcase
    endfunction

endpackage

//--- core/otsc_clock_output_control_div.sv
/*
 * clock-out divider: one output pulse per (divider + 1) source ticks.
 * assumes: src_tick is a one-cycle strobe synchronous to pclk.
 */
`timescale 1ns/10ps
`include "otsc_map.svh"

module otsc_clock_output_control_div
    import otsc_pkg::*;
#(
    parameter int DIV_W = 5
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic src_tick,
    input wire logic [DIV_W-1:0] div,
    output logic clk_pulse
);

    logic [DIV_W-1:0] cnt_ff;
    logic pulse_ff;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////
    // tick counter, held clear while disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= '0;
        end else if (!enable) begin
            cnt_ff <= '0;
        end else if (src_tick) begin
            cnt_ff <= (cnt_ff >= div) ? '0 : cnt_ff + 1'b1;
        end
    end

    // output pulse on the last tick of each group
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_ff <= 1'b0;
        end else begin
            pulse_ff <= enable && src_tick && (cnt_ff >= div);
        end
    end

    assign clk_pulse = pulse_ff;

    ////////////////////////////////////////////////////////////////////
    a_div_disabled: assert property (!enable |=> !clk_pulse)
        else $error("clock out pulsed while disabled");

    a_div_terminal: assert property (clk_pulse |-> $past(src_tick) &&
        $past(cnt_ff) == $past(div))
        else $error("clock out pulse not on divider terminal count");

endmodule

//--- core/otsc_top.sv
/*
 * oscillator control: fast oscillator coarse and fine trim with a
 * triangular spread-spectrum sweep, slow oscillator trim and range,
 * slow clock derivation, clock-out source select and divider, apb slave.
 * assumes: pclk is the fast oscillator clock; sys_clk_tick and
 * slow_osc_tick are one-cycle strobes synchronous to pclk.
 */
// Function
// - sweep rate zero disables spread; fine trim passes straight to oscillator
// - amplitude codes 0..3 give deviation of 4, 8, 16, 32 counts
// - swept code stays within fine trim plus or minus the deviation
// - sweep rate sets cycles between updates; full sweep 4*rate*(2*dev+1)
// - swept code saturates at 0 and 255, never wraps
// - coarse trim bits 1:0, amplitude bits 3:2, rate bits 7:4
// - fast oscillator stops while cpu is in stop or sleep
// - slow trim bit 4 selects 256 kHz range, default 128 kHz
// - slow clock is 128 kHz and derived clock 32 kHz in either range
// - slow oscillator is never powered down
// - clock-out enable bit 7 clear disables output, set enables divider
// - source 00 system, 01 fast, 10 derived slow, 11 like system
// - output is source divided by divider field plus one
`timescale 1ns/10ps
`include "otsc_map.svh"

module otsc_top
    import otsc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic write_protection_unlock,
    input wire logic cpu_low_power,
    input wire logic sys_clk_tick,
    input wire logic slow_osc_tick,
    output logic [1:0] coarse_trim,
    output logic [7:0] swept_trim_code,
    output logic fast_osc_run,
    output logic slow_osc_enable,
    output logic slow_osc_range,
    output logic [3:0] slow_osc_trim,
    output logic slow_clk_tick,
    output logic derived_slow_clock,
    output logic clock_output
);

    otsc_coarse_t coarse_ff;
    logic [7:0] fine_ff;
    otsc_clock_output_control_t clock_output_control_ff;
    otsc_slow_t slow_ff;
    logic [31:0] prdata_ff;
    logic [4:0] tick_cnt_ff;
    logic signed [6:0] off_ff;
    otsc_dir_t dir_ff;
    logic [7:0] swept_ff;
    logic fast_run_ff;
    logic half_ff;
    logic [1:0] q_cnt_ff;
    logic slow128_ff;
    logic slow32_ff;
    logic sweep_on;
    logic update;
    logic [4:0] interval_m1;
    logic [5:0] dev;
    logic signed [6:0] dev_s;
    logic signed [9:0] sum;
    logic wr_en;
    logic mapped;
    logic src_tick;
    logic slow128_raw;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // address match against a register index
    function automatic logic hit(input logic [17:0] a, input logic [15:0] idx);
        hit = (a == {idx, 2'b00});
    endfunction

    // saturate a signed sum into the 8-bit trim range
    function automatic logic [7:0] clamp8(input logic signed [9:0] v);
        if (v < `OTSC_TRIM_MIN) begin
            clamp8 = 8'h00;
        end else if (v > `OTSC_TRIM_MAX) begin
            clamp8 = 8'hFF;
        end else begin
            clamp8 = v[7:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // apb decode, zero wait states
    assign mapped = hit(paddr, `OTSC_IDX_COARSE) || hit(paddr, `OTSC_IDX_FINE) ||
        hit(paddr, `OTSC_IDX_CLOCK_OUTPUT_CONTROL) || hit(paddr, `OTSC_IDX_SLOW) ||
        hit(paddr, `OTSC_IDX_STATUS);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign wr_en = psel && penable && pwrite && mapped;
    assign prdata = prdata_ff;

    // read data captured in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= '0;
        end else if (psel && !penable && !pwrite) begin
            if (hit(paddr, `OTSC_IDX_COARSE)) begin
                prdata_ff <= {24'h000000, coarse_ff};
            end else if (hit(paddr, `OTSC_IDX_FINE)) begin
                prdata_ff <= {24'h000000, fine_ff};
            end else if (hit(paddr, `OTSC_IDX_CLOCK_OUTPUT_CONTROL)) begin
                prdata_ff <= {24'h000000, clock_output_control_ff};
            end else if (hit(paddr, `OTSC_IDX_SLOW)) begin
                prdata_ff <= {24'h000000, slow_ff};
            end else if (hit(paddr, `OTSC_IDX_STATUS)) begin
                prdata_ff <= {24'h000000, swept_ff};
            end else begin
                prdata_ff <= '0;
            end
        end
    end

    // protected trim registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coarse_ff <= `OTSC_RST_COARSE;
            fine_ff <= `OTSC_RST_FINE;
            slow_ff <= `OTSC_RST_SLOW;
        end else if (wr_en && write_protection_unlock) begin
            if (hit(paddr, `OTSC_IDX_COARSE)) begin
                coarse_ff <= otsc_coarse_t'(pwdata[7:0]);
            end
            if (hit(paddr, `OTSC_IDX_FINE)) begin
                fine_ff <= pwdata[7:0];
            end
            if (hit(paddr, `OTSC_IDX_SLOW)) begin
                slow_ff <= otsc_slow_t'(pwdata[7:0] & `OTSC_SLOW_WR_MASK);
            end
        end
    end

    // clock-out control, not protected
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_output_control_ff <= `OTSC_RST_CLOCK_OUTPUT_CONTROL;
        end else if (wr_en && hit(paddr, `OTSC_IDX_CLOCK_OUTPUT_CONTROL)) begin
            clock_output_control_ff <= otsc_clock_output_control_t'(pwdata[7:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sweep control terms
    assign sweep_on = (coarse_ff.sweep_rate != `OTSC_RATE_OFF);
    assign dev = otsc_dev(coarse_ff.sweep_amplitude);
    assign dev_s = signed'({1'b0, dev});
    assign interval_m1 = {coarse_ff.sweep_rate, 1'b0} - 5'h01;
    assign update = sweep_on && (tick_cnt_ff >= interval_m1);
    assign sum = signed'({2'b00, fine_ff}) + {{3{off_ff[6]}}, off_ff};

    // update interval counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_ff <= '0;
        end else if (!sweep_on || update) begin
            tick_cnt_ff <= '0;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 5'h01;
        end
    end

    // triangular offset walk; a reversal costs one update
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            off_ff <= '0;
            dir_ff <= DIR_UP;
        end else if (!sweep_on) begin
            off_ff <= '0;
            dir_ff <= DIR_UP;
        end else if (off_ff > dev_s) begin
            off_ff <= dev_s;
        end else if (off_ff < -dev_s) begin
            off_ff <= -dev_s;
        end else if (update) begin
            case (dir_ff)
                DIR_UP: begin
                    if (off_ff >= dev_s) begin
                        dir_ff <= DIR_DOWN;
                    end else begin
                        off_ff <= off_ff + 7'sh01;
                    end
                end
                DIR_DOWN: begin
                    if (off_ff <= -dev_s) begin
                        dir_ff <= DIR_UP;
                    end else begin
                        off_ff <= off_ff - 7'sh01;
                    end
                end
                default: begin
                    dir_ff <= DIR_UP;
                end
            endcase
        end
    end

    // code sent to the oscillator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            swept_ff <= `OTSC_RST_FINE;
        end else if (sweep_on) begin
            swept_ff <= clamp8(sum);
        end else begin
            swept_ff <= fine_ff;
        end
    end

    // fast oscillator run request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_run_ff <= 1'b1;
        end else begin
            fast_run_ff <= !cpu_low_power;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // slow clock derivation: halve in the high range, then divide by four
    assign slow128_raw = slow_osc_tick && (!slow_ff.slow_osc_range || half_ff);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_ff <= 1'b0;
            q_cnt_ff <= '0;
            slow128_ff <= 1'b0;
            slow32_ff <= 1'b0;
        end else begin
            if (slow_osc_tick) begin
                half_ff <= !half_ff;
            end
            if (slow128_raw) begin
                q_cnt_ff <= q_cnt_ff + 2'h1;
            end
            slow128_ff <= slow128_raw;
            slow32_ff <= slow128_raw && (q_cnt_ff == `OTSC_SLOW32_LAST);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // clock-out source select
    always_comb begin
        case (clock_output_control_ff.clock_output_source)
            SRC_FAST: src_tick = 1'b1;
            SRC_SLOW32: src_tick = slow32_ff;
            default: src_tick = sys_clk_tick;
        endcase
    end

    otsc_clock_output_control_div #(
        .DIV_W(5)
    ) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .enable(clock_output_control_ff.clock_output_enable),
        .src_tick(src_tick),
        .div(clock_output_control_ff.clock_output_divider),
        .clk_pulse(clock_output)
    );

    // remaining outputs
    assign coarse_trim = coarse_ff.coarse_trim;
    assign swept_trim_code = swept_ff;
    assign fast_osc_run = fast_run_ff;
    assign slow_osc_enable = 1'b1;
    assign slow_osc_range = slow_ff.slow_osc_range;
    assign slow_osc_trim = slow_ff.trim;
    assign slow_clk_tick = slow128_ff;
    assign derived_slow_clock = slow32_ff;

    ////////////////////////////////////////////////////////////////////
    sequence s_top_turn;
        update && dir_ff == DIR_UP && off_ff == dev_s ##1 dir_ff == DIR_DOWN;
    endsequence

    a_sweep_bypass: assert property (!sweep_on |=> swept_trim_code == $past(fine_ff))
        else $error("fine trim not passed through with sweep off");

    a_amp_decode: assert property (dev == (6'h04 << coarse_ff.sweep_amplitude))
        else $error("deviation decode wrong");

    a_offset_window: assert property (sweep_on && $stable(coarse_ff) |->
        off_ff <= dev_s && off_ff >= -dev_s)
        else $error("sweep offset outside deviation");

    a_code_clip: assert property (sweep_on && sum > `OTSC_TRIM_MAX |=>
        swept_trim_code == 8'hFF)
        else $error("swept code not clipped at top");

    a_step_up: assert property (update && dir_ff == DIR_UP && off_ff < dev_s &&
        $stable(coarse_ff) |=> off_ff == $past(off_ff) + 7'sh01)
        else $error("rising sweep step wrong");

    a_turn_hold: assert property (s_top_turn |-> off_ff == $past(off_ff))
        else $error("offset moved on reversal");

    a_update_gap: assert property (update && coarse_ff.sweep_rate == 4'h1 &&
        $stable(coarse_ff) ##1 $stable(coarse_ff) |-> !update)
        else $error("update repeated too soon for rate one");

    a_update_next: assert property (update && coarse_ff.sweep_rate == 4'h1 &&
        $stable(coarse_ff) ##1 $stable(coarse_ff) [*2] |-> update)
        else $error("update missing for rate one");

    a_fast_stop: assert property (cpu_low_power |=> !fast_osc_run)
        else $error("fast oscillator running in low power");

    a_slow_low: assert property (!slow_ff.slow_osc_range && slow_osc_tick |=>
        slow_clk_tick)
        else $error("slow clock tick missing in low range");

    a_lock_write: assert property (wr_en && !write_protection_unlock |=>
        $stable(fine_ff) && $stable(coarse_ff) && $stable(slow_ff))
        else $error("locked trim register changed");

endmodule

//--- verification/osc_trim_spread_clock_output_control_tb.sv
/*
 * self-checking bench of the oscillator trim, spread and clock-out block:
 * apb register access, write protection, sweep shape, clock-out, slow clocks.
 * assumes: otsc_pkg compiled first and otsc_map.svh on the include path.
 */
`timescale 1ns/10ps
`include "otsc_map.svh"

module osc_trim_spread_clock_output_control_tb
    import otsc_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [17:0] paddr = 18'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic write_protection_unlock = 1'b0;
    logic cpu_low_power = 1'b0;
    logic sys_clk_tick = 1'b0;
    logic slow_osc_tick = 1'b0;
    logic [1:0] coarse_trim;
    logic [7:0] swept_trim_code;
    logic fast_osc_run, slow_osc_enable, slow_osc_range;
    logic [3:0] slow_osc_trim;
    logic slow_clk_tick, derived_slow_clock, clock_output;
    logic [15:0] lfsr = 16'h5AEE;
    logic tick_en = 1'b0;
    logic run = 1'b0;
    int fails = 0;
    int checks_done = 0;
    int n_sys, n_slow, n_sct, n_der, n_out;
    int mdl[int];
    logic [31:0] v;
    logic e;
    int divs[4] = '{0, 1, 4, 31};

    otsc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .write_protection_unlock(write_protection_unlock),
        .cpu_low_power(cpu_low_power), .sys_clk_tick(sys_clk_tick),
        .slow_osc_tick(slow_osc_tick), .coarse_trim(coarse_trim),
        .swept_trim_code(swept_trim_code), .fast_osc_run(fast_osc_run),
        .slow_osc_enable(slow_osc_enable), .slow_osc_range(slow_osc_range),
        .slow_osc_trim(slow_osc_trim), .slow_clk_tick(slow_clk_tick),
        .derived_slow_clock(derived_slow_clock), .clock_output(clock_output));

    ////////////////////////////////////////////////////////////////////////////
    // clock, random source strobes and pulse counters
    always #25 pclk = ~pclk;

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // strobes are gated so windows can start and end with no tick in flight
    always @(posedge pclk) begin
        lfsr <= lfsr_next(lfsr);
        sys_clk_tick <= tick_en & lfsr[0];
        slow_osc_tick <= tick_en & lfsr[5] & lfsr[9];
    end

    // counts what the design sees and makes while a window runs
    always @(posedge pclk) begin
        if (run) begin
            n_sys += int'(sys_clk_tick === 1'b1);
            n_slow += int'(slow_osc_tick === 1'b1);
            n_sct += int'(slow_clk_tick === 1'b1);
            n_der += int'(derived_slow_clock === 1'b1);
            n_out += int'(clock_output === 1'b1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // compare and report
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_cnt(input int got, input int exp);
        checks_done++;
        if (got != exp) begin
            fails++;
            $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // apb master and register model
    task automatic apb(input logic [15:0] idx, input logic wr, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        logic rdy;
        n = 0;
        rdy = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        // request stands until pready is seen high at a rising edge
        do begin
            @(posedge pclk);
            rdy = pready;
            rd = prdata;
            err = pslverr;
            n++;
        end while (rdy !== 1'b1 && n < 20);
        if (rdy !== 1'b1) begin
            fails++;
            complete_run();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wreg(input logic [15:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic er;
        apb(idx, 1'b1, d, r, er);
        if (mdl.exists(idx) && (idx == `OTSC_IDX_CLOCK_OUTPUT_CONTROL || write_protection_unlock))
            mdl[idx] = (idx == `OTSC_IDX_SLOW) ? int'(d & `OTSC_SLOW_WR_MASK) : int'(d);
    endtask

    task automatic rreg(input logic [15:0] idx, output logic [31:0] d);
        logic er;
        apb(idx, 1'b0, 8'h00, d, er);
    endtask

    // counting window of n cycles with strobes on or off, then a quiet tail
    task automatic window(input int n, input logic gate);
        @(negedge pclk);
        {n_sys, n_slow, n_sct, n_der, n_out} = '0;
        @(posedge pclk);
        run <= 1'b1;
        tick_en <= gate;
        repeat (n) @(posedge pclk);
        tick_en <= 1'b0;
        repeat (6) @(posedge pclk);
        run <= 1'b0;
        @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic sweep(input int rate, input int amp, input int fine);
        int dev, lo, hi, p, mn, mx, prev, cur, t1, t2, bad;
        dev = 4 << amp;
        lo = (fine - dev < 0) ? 0 : fine - dev;
        hi = (fine + dev > 255) ? 255 : fine + dev;
        p = 4 * rate * (2 * dev + 1);
        wreg(`OTSC_IDX_COARSE, 8'h01);
        wreg(`OTSC_IDX_FINE, fine[7:0]);
        repeat (2) @(negedge pclk);
        check_val(swept_trim_code, fine);
        wreg(`OTSC_IDX_COARSE, {rate[3:0], amp[1:0], 2'h1});
        mn = 999;
        mx = -1;
        prev = fine;
        t1 = -1;
        t2 = -1;
        bad = 0;
        for (int c = 0; c < 3 * p; c++) begin
            @(negedge pclk);
            cur = swept_trim_code;
            bad += int'($isunknown(swept_trim_code));
            mn = (cur < mn) ? cur : mn;
            mx = (cur > mx) ? cur : mx;
            bad += int'(cur - prev > 1 || prev - cur > 1);
            if (cur == hi && prev != hi) {t1, t2} = {t2, c};
            prev = cur;
        end
        check_cnt(mn, lo);
        check_cnt(mx, hi);
        check_cnt(bad, 0);
        check_cnt(t2 - t1, p);
    endtask

    task automatic clk_case(input otsc_src_t src, input int div, input logic en);
        wreg(`OTSC_IDX_CLOCK_OUTPUT_CONTROL, 8'(mdl[`OTSC_IDX_CLOCK_OUTPUT_CONTROL]) & 8'h7F);
        wreg(`OTSC_IDX_CLOCK_OUTPUT_CONTROL, {1'b0, src, div[4:0]});
        wreg(`OTSC_IDX_CLOCK_OUTPUT_CONTROL, {en, src, div[4:0]});
        if (src == SRC_FAST) begin
            window(16 * (div + 1) - 6, 1'b0);
            check_cnt(n_out, en ? 16 : 0);
        end else begin
            window(300, 1'b1);
            check_cnt(n_out, en ? n_sys / (div + 1) : 0);
        end
    endtask

    task automatic slow_case(input logic range);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        wreg(`OTSC_IDX_SLOW, {3'h0, range, 4'h8});
        wreg(`OTSC_IDX_CLOCK_OUTPUT_CONTROL, {1'b1, SRC_SLOW32, 5'h01});
        cpu_low_power <= 1'b1;
        window(1200, 1'b1);
        check_val(slow_osc_range, range);
        check_val(slow_osc_enable, 1'b1);
        check_cnt(n_sct, range ? n_slow / 2 : n_slow);
        check_cnt(n_der, range ? n_slow / 8 : n_slow / 4);
        check_cnt(n_out, n_der / 2);
        cpu_low_power <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // watchdog
    initial begin
        #2500000;
        fails++;
        complete_run();
    end

    // main sequence
    initial begin
        mdl[`OTSC_IDX_COARSE] = `OTSC_RST_COARSE;
        mdl[`OTSC_IDX_FINE] = `OTSC_RST_FINE;
        mdl[`OTSC_IDX_CLOCK_OUTPUT_CONTROL] = `OTSC_RST_CLOCK_OUTPUT_CONTROL;
        mdl[`OTSC_IDX_SLOW] = `OTSC_RST_SLOW;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        check_val(coarse_trim, 2'h1);
        check_val(slow_osc_range, 1'b0);
        check_val(fast_osc_run, 1'b1);
        apb(16'hA003, 1'b0, 8'h00, v, e);
        check_val(e, 1'b1);
        check_val(v, 32'h0);
        // protected writes ignored while locked, clock-out always writable
        wreg(`OTSC_IDX_FINE, 8'h33);
        wreg(`OTSC_IDX_SLOW, 8'hF1);
        wreg(`OTSC_IDX_CLOCK_OUTPUT_CONTROL, 8'h25);
        write_protection_unlock <= 1'b1;
        wreg(`OTSC_IDX_COARSE, 8'h0E);
        @(negedge pclk);
        check_val(coarse_trim, 2'h2);
        wreg(`OTSC_IDX_SLOW, 8'hFF);
        @(negedge pclk);
        check_val(slow_osc_trim, 4'hF);
        foreach (mdl[i]) begin
            rreg(16'(i), v);
            check_val(v, mdl[i]);
        end
        rreg(`OTSC_IDX_STATUS, v);
        check_val(v, mdl[`OTSC_IDX_FINE]);
        // fast oscillator follows the cpu low-power input
        @(posedge pclk);
        cpu_low_power <= 1'b1;
        repeat (2) @(negedge pclk);
        check_val(fast_osc_run, 1'b0);
        @(posedge pclk);
        cpu_low_power <= 1'b0;
        repeat (2) @(negedge pclk);
        check_val(fast_osc_run, 1'b1);
        for (int a = 0; a < 4; a++) sweep(1, a, 128);
        sweep(2, 1, 128);
        sweep(15, 0, 2);
        sweep(1, 2, 248);
        wreg(`OTSC_IDX_COARSE, 8'h01);
        foreach (divs[k]) begin
            clk_case(SRC_FAST, divs[k], 1'b1);
            clk_case(SRC_SYS, divs[k], 1'b1);
        end
        clk_case(SRC_RSVD, 2, 1'b1);
        clk_case(SRC_SYS, 1, 1'b0);
        slow_case(1'b1);
        slow_case(1'b0);
        complete_run();
    end
endmodule
